// file: core/graphics_port_hub.sv
`timescale 1ns/1ps
`include "graphics_port_cfg.svh"
// Function
// - The claim line is driven active only to claim a frame-based access, never for pipelined.
// - Grant is given for an active request or to announce data of a queued transfer.
// - Every grant carries a three-bit status code telling what it is for.
// - Address/data carries addresses and data, at single rate during frame-based cycles.
// - Queued data phases move at the chosen rate of one, four or eight items per period.
// - Command/byte-enable lines carry command then byte enables at the address/data rate.
// - Byte enables are never used to qualify read data of queued reads.
// - Parity is checked only in frame-based transactions; it is driven in frame reads and every turn-around while is_write is clear.
// - The inversion flag set means the low sixteen data lines travel inverted.
// - Inversion is used only in the low-swing mode and travels with the upper strobes.
// - The port offers no locked cycles at all.
// - All port logic is cleared by the system reset input.
// - Conventional transactions keep the plain local-bus meaning of every shared line.
// - Frame marks frame-based transfers and stays inactive during pipelined ones.
module graphics_port_hub
  import graphics_port_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_mode3,
  input wire logic [1:0] i_rate_sel,
  input wire logic i_port_bus_request,
  input wire logic i_pipelined_request,
  input wire logic i_port_frame,
  output logic o_port_bus_grant,
  output logic [2:0] o_grant_status_code,
  output logic o_target_claim,
  output logic o_target_claim_oe_n,
  input wire logic [31:0] i_port_addr_data,
  output logic [31:0] o_port_addr_data,
  output logic o_port_addr_data_oe_n,
  input wire logic [3:0] i_port_cmd_byte_en,
  output logic [3:0] o_port_cmd_byte_en,
  output logic o_port_cmd_byte_en_oe_n,
  input wire logic i_port_parity,
  output logic o_port_parity,
  output logic o_port_parity_oe_n,
  input wire logic i_low_half_invert_flag,
  output logic o_low_half_invert_flag,
  output logic o_low_half_invert_flag_oe_n,
  output logic o_upper_first_strobe,
  output logic o_upper_second_strobe,
  input wire logic i_queue_valid,
  input wire logic i_queue_write,
  input wire logic [3:0] i_queue_len,
  output logic o_queue_ready,
  input wire logic [31:0] i_tx_data,
  output logic o_tx_take,
  output logic o_addr_valid,
  output logic o_addr_pipelined,
  output logic [31:0] o_addr,
  output logic [3:0] o_cmd,
  output logic o_rx_valid,
  output logic [31:0] o_rx_data,
  output logic [3:0] o_rx_be,
  output logic o_parity_error
);
  hub_link_if lk ();

  port_state_t state;
  logic [`PIN_SYNC_WIDTH-1:0] pin_meta;
  logic [`PIN_SYNC_WIDTH-1:0] pin_sync;
  logic s_mode3, s_req, s_pipe, s_frame, s_par, s_dbi;
  logic [31:0] s_ad;
  logic [3:0] s_cbe;
  logic req_act, pipe_act, frame_act, frame_prev;
  logic [3:0] cbe_act;
  logic grant_act, claim_act, is_write, q_write;
  logic [3:0] q_left;
  logic par_calc, par_check;
  logic [15:0] low_prev;
  logic item_odd;
  logic [31:0] ad_out;
  logic dbi_out, par_out;

  // Level on a control pin for an internal active state
  function automatic logic pin_level(input logic act, input logic mode3);
    pin_level = mode3 ? act : ~act;
  endfunction

  beat_rate_divider u_div (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .lk(lk.tick_src)
  );

  low_half_inverter u_inv (
    .lk(lk.codec)
  );

  // Two-stage synchroniser for every pin input and the mode strap
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= {i_mode3, i_port_bus_request, i_pipelined_request, i_port_frame,
        i_port_parity, i_low_half_invert_flag, i_port_cmd_byte_en, i_port_addr_data};
      pin_sync <= pin_meta;
    end
  end

  assign {s_mode3, s_req, s_pipe, s_frame, s_par, s_dbi, s_cbe, s_ad} = pin_sync;

  // Pin polarity follows the signalling mode
  assign req_act = pin_level(s_req, s_mode3);
  assign pipe_act = pin_level(s_pipe, s_mode3);
  assign frame_act = pin_level(s_frame, s_mode3);
  assign cbe_act = s_mode3 ? s_cbe : ~s_cbe;

  // Divider and encoder hookup
  assign lk.rate = rate_t'(i_rate_sel);
  assign lk.enable = s_mode3;
  assign lk.raw = i_tx_data[15:0];
  assign lk.prev = low_prev;

  // Sequencer; no locked cycle exists on this port
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (lk.tick_1x) begin
            if (frame_act && !frame_prev) begin
              state <= ((s_ad & `CLAIM_MASK) == `CLAIM_BASE) ? ST_FDATA : ST_IDLE;
            end else if (i_queue_valid && i_queue_len != 4'h0) begin
              state <= ST_QDATA;
            end else if (req_act) begin
              state <= ST_OWN;
            end
          end
        end
        ST_OWN: begin
          if (lk.tick_1x) begin
            if (frame_act && !frame_prev
                && (s_ad & `CLAIM_MASK) == `CLAIM_BASE) begin
              state <= ST_FDATA;
            end else if (!req_act && !frame_act && !pipe_act) begin
              state <= ST_IDLE;
            end
          end
        end
        ST_FDATA: begin
          if (lk.tick_1x && !frame_act) begin
            state <= ST_TURN;
          end
        end
        ST_TURN: begin
          if (lk.tick_1x) begin
            state <= ST_IDLE;
          end
        end
        ST_QDATA: begin
          // Turn only after the last item has stood one item period
          if (lk.tick_item && q_left == 4'h0) begin
            state <= ST_TURN;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Grant and its status code
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      grant_act <= 1'b0;
      o_grant_status_code <= `GRANT_IDLE_CODE;
    end else if (state == ST_IDLE && lk.tick_1x && !(frame_act && !frame_prev)) begin
      if (i_queue_valid && i_queue_len != 4'h0) begin
        grant_act <= 1'b1;
        o_grant_status_code <= i_queue_write ? `GRANT_WRITE_DATA : `GRANT_READ_DATA;
      end else if (req_act) begin
        grant_act <= 1'b1;
        o_grant_status_code <= `GRANT_MASTER_START;
      end
    end else if (state == ST_OWN && lk.tick_1x && !req_act) begin
      grant_act <= 1'b0;
    end else if (state == ST_QDATA && lk.tick_item) begin
      grant_act <= 1'b0;
    end else if (state == ST_FDATA || state == ST_TURN) begin
      grant_act <= 1'b0;
    end
  end

  assign o_port_bus_grant = pin_level(grant_act, s_mode3);
  assign o_queue_ready = (state == ST_IDLE) && lk.tick_1x && !(frame_act && !frame_prev);

  // Frame edge tracking at single rate
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      frame_prev <= 1'b0;
    end else if (lk.tick_1x) begin
      frame_prev <= frame_act;
    end
  end

  // Address capture for frame-based and pipelined requests
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_addr_valid <= 1'b0;
      o_addr_pipelined <= 1'b0;
      o_addr <= 32'h0;
      o_cmd <= 4'h0;
      is_write <= 1'b0;
    end else begin
      o_addr_valid <= 1'b0;
      if (lk.tick_1x && (state == ST_IDLE || state == ST_OWN)) begin
        if (frame_act && !frame_prev) begin
          o_addr_valid <= 1'b1;
          o_addr_pipelined <= 1'b0;
          o_addr <= s_ad;
          o_cmd <= cbe_act;
          is_write <= cbe_act[`CMD_WRITE_BIT];
        end else if (pipe_act && !frame_act && state == ST_OWN) begin
          o_addr_valid <= 1'b1;
          o_addr_pipelined <= 1'b1;
          o_addr <= s_ad;
          o_cmd <= cbe_act;
        end
      end
    end
  end

  // Claim the access only for frame-based cycles that hit the window
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      claim_act <= 1'b0;
    end else if (state == ST_IDLE || state == ST_OWN) begin
      claim_act <= lk.tick_1x && frame_act && !frame_prev
        && (s_ad & `CLAIM_MASK) == `CLAIM_BASE;
    end else if (state == ST_TURN && lk.tick_1x) begin
      claim_act <= 1'b0;
    end
  end

  assign o_target_claim = pin_level(claim_act, s_mode3);
  assign o_target_claim_oe_n = !(state == ST_FDATA || state == ST_TURN);

  // Queued transfer length and item phase
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q_left <= 4'h0;
      q_write <= 1'b0;
      item_odd <= 1'b1;
    end else if (o_queue_ready && i_queue_valid && i_queue_len != 4'h0) begin
      q_left <= i_queue_len;
      q_write <= i_queue_write;
      item_odd <= 1'b1;
    end else if (state == ST_QDATA && lk.tick_item && q_left != 4'h0) begin
      q_left <= q_left - 4'h1;
      item_odd <= ~item_odd;
    end
  end

  assign o_tx_take = (state == ST_QDATA) && lk.tick_item && !q_write && q_left != 4'h0;

  // Outbound data: frame read at single rate, queued read at channel rate
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ad_out <= 32'h0;
      dbi_out <= 1'b0;
      low_prev <= 16'h0;
      o_upper_first_strobe <= 1'b0;
      o_upper_second_strobe <= 1'b0;
    end else if (o_tx_take) begin
      ad_out <= {i_tx_data[31:16], lk.coded};
      dbi_out <= lk.invert;
      low_prev <= lk.coded;
      o_upper_first_strobe <= item_odd;
      o_upper_second_strobe <= ~item_odd;
    end else if (state == ST_FDATA && lk.tick_1x && !is_write) begin
      ad_out <= i_tx_data;
      dbi_out <= 1'b0;
    end else if (state == ST_TURN) begin
      // Park both strobes so the next first item gives a rising edge
      o_upper_first_strobe <= 1'b0;
      o_upper_second_strobe <= 1'b0;
    end
  end

  assign o_port_addr_data = ad_out;
  assign o_low_half_invert_flag = dbi_out;
  assign o_port_addr_data_oe_n = !((state == ST_FDATA && !is_write)
    || (state == ST_QDATA && !q_write));
  assign o_low_half_invert_flag_oe_n = !(state == ST_QDATA && !q_write && s_mode3);
  // Byte enables stay inactive for queued read data
  assign o_port_cmd_byte_en = s_mode3 ? 4'h0 : 4'hf;
  assign o_port_cmd_byte_en_oe_n = !(state == ST_QDATA && !q_write);

  // Inbound data: frame writes at single rate, queued writes at channel rate
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_rx_valid <= 1'b0;
      o_rx_data <= 32'h0;
      o_rx_be <= 4'h0;
    end else begin
      o_rx_valid <= 1'b0;
      if (state == ST_FDATA && lk.tick_1x && is_write && frame_prev) begin
        o_rx_valid <= 1'b1;
        o_rx_data <= s_ad;
        o_rx_be <= cbe_act;
      end else if (state == ST_QDATA && lk.tick_item && q_write && q_left != 4'h0) begin
        o_rx_valid <= 1'b1;
        o_rx_data <= {s_ad[31:16], s_ad[15:0] ^ {16{s_dbi && s_mode3}}};
        o_rx_be <= cbe_act;
      end
    end
  end

  // Parity: computed over each frame phase, checked one period later
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      par_calc <= 1'b0;
      par_check <= 1'b0;
      par_out <= 1'b0;
      o_parity_error <= 1'b0;
    end else begin
      o_parity_error <= 1'b0;
      if (lk.tick_1x) begin
        par_check <= (frame_act && !frame_prev && claim_act == 1'b0
          && (state == ST_IDLE || state == ST_OWN)) || (state == ST_FDATA && is_write);
        par_calc <= ^{s_ad, s_cbe};
        par_out <= ^{ad_out, s_cbe};
        if (par_check && (state == ST_FDATA || state == ST_TURN)) begin
          o_parity_error <= (par_calc != s_par);
        end
      end
    end
  end

  assign o_port_parity = par_out;
  assign o_port_parity_oe_n = !((state == ST_FDATA || state == ST_TURN) && !is_write);

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_claim_frame_only: assert property (
    claim_act |-> !o_target_claim_oe_n && !o_addr_pipelined)
    else $error("claim driven outside a frame access");
  a_grant_needs_cause: assert property (
    $rose(grant_act) |-> $past(req_act) || $past(i_queue_valid))
    else $error("grant without request or queued transfer");
  a_grant_status_code: assert property (
    $rose(grant_act) && state == ST_QDATA |->
      o_grant_status_code == (q_write ? `GRANT_WRITE_DATA : `GRANT_READ_DATA))
    else $error("grant status does not match queued direction");
  a_frame_data_rate: assert property (
    state == ST_FDATA && !lk.tick_1x |=> $stable(ad_out))
    else $error("frame data changed between single-rate periods");
  a_queued_item_count: assert property (
    state == ST_QDATA && lk.tick_item && q_left == 4'h0 |=> state == ST_TURN)
    else $error("queued transfer did not end after its last item");
  a_read_be_unused: assert property (
    state == ST_QDATA && !q_write |-> o_port_cmd_byte_en == (s_mode3 ? 4'h0 : 4'hf))
    else $error("byte enables asserted on queued read data");
  a_parity_frame_only: assert property (
    state == ST_QDATA || state == ST_OWN |-> o_port_parity_oe_n && !o_parity_error)
    else $error("parity active outside frame-based transfer");
  a_invert_mode_only: assert property (
    !s_mode3 && o_tx_take |=> !dbi_out)
    else $error("low-half inversion used in 2.0 mode");
  a_invert_restores: assert property (
    o_tx_take |=> (dbi_out ? ~ad_out[15:0] : ad_out[15:0]) == $past(i_tx_data[15:0]))
    else $error("inverted half does not restore the data");
  a_grant_polarity: assert property (
    !grant_act |-> o_port_bus_grant == !s_mode3)
    else $error("grant pin polarity wrong for mode");
endmodule // graphics_port_hub

// file: common/graphics_port_cfg.svh
`ifndef GRAPHICS_PORT_CFG_SVH
`define GRAPHICS_PORT_CFG_SVH

// System clock
`define CLK_PERIOD_PS 25000
// Single-rate period expressed in system cycles
`define PORT_1X_PERIOD_PS 200000
`define PORT_1X_CYCLES (`PORT_1X_PERIOD_PS / `CLK_PERIOD_PS)
`define PORT_DIV_LAST 3'h7

// Grant status codes driven with each grant
`define GRANT_READ_DATA 3'h0
`define GRANT_WRITE_DATA 3'h2
`define GRANT_MASTER_START 3'h7
`define GRANT_IDLE_CODE 3'h7

// Command field: bit that marks a write command
`define CMD_WRITE_BIT 0

// Address window that this target claims for frame-based accesses
`define CLAIM_BASE 32'h0010_0000
`define CLAIM_MASK 32'hfff0_0000

// Low-half inversion coding
`define LOW_HALF_WIDTH 16
`define LOW_HALF_LIMIT 5'h08

// Pin bundle width passing the input synchroniser
`define PIN_SYNC_WIDTH 42

`endif

// file: common/graphics_port_pkg.sv
package graphics_port_pkg;

  // Port sequencer states, Gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_OWN = 3'h1,
    ST_FDATA = 3'h3,
    ST_TURN = 3'h2,
    ST_QDATA = 3'h6
  } port_state_t;

  // Channel transfer rate
  typedef enum logic [1:0] {
    RATE_1X = 2'h0,
    RATE_4X = 2'h1,
    RATE_8X = 2'h2
  } rate_t;

endpackage

// file: common/hub_link_if.sv
`timescale 1ns/1ps
interface hub_link_if;
  import graphics_port_pkg::*;
  // Rate divider group
  rate_t rate;
  logic tick_1x;
  logic tick_item;
  // Low-half inversion encoder group
  logic enable;
  logic [15:0] raw;
  logic [15:0] prev;
  logic invert;
  logic [15:0] coded;

  modport tick_src (input rate, output tick_1x, output tick_item);
  modport codec (input enable, input raw, input prev, output invert, output coded);
  modport core (output rate, input tick_1x, input tick_item,
    output enable, output raw, output prev, input invert, input coded);
endinterface

// file: core/beat_rate_divider.sv
`timescale 1ns/1ps
`include "graphics_port_cfg.svh"
module beat_rate_divider
  import graphics_port_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst,
  hub_link_if.tick_src lk
);
  logic [2:0] cnt;

  // Free-running divider for the single-rate period
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 3'h0;
    end else begin
      cnt <= cnt + 3'h1;
    end
  end

  // Item pulses: one, four or eight per single-rate period
  always_comb begin
    lk.tick_1x = (cnt == `PORT_DIV_LAST);
    case (lk.rate)
      RATE_1X: lk.tick_item = (cnt == `PORT_DIV_LAST);
      RATE_4X: lk.tick_item = cnt[0];
      RATE_8X: lk.tick_item = 1'b1;
      default: lk.tick_item = (cnt == `PORT_DIV_LAST);
    endcase
  end
endmodule // beat_rate_divider

// file: core/low_half_inverter.sv
`timescale 1ns/1ps
`include "graphics_port_cfg.svh"
module low_half_inverter (
  hub_link_if.codec lk
);
  logic [4:0] flips;

  // Count lines that would toggle against the last driven half
  always_comb begin
    flips = 5'h0;
    for (int i = 0; i < `LOW_HALF_WIDTH; i++) begin
      flips = flips + {4'h0, lk.raw[i] ^ lk.prev[i]};
    end
  end

  // Invert when more than half the lines would toggle
  always_comb begin
    lk.invert = lk.enable && (flips > `LOW_HALF_LIMIT);
    lk.coded = lk.invert ? ~lk.raw : lk.raw;
  end
endmodule // low_half_inverter

// file: tb/graphics_device_model.sv
`timescale 1ns/1ps
// Graphics master on the far side of the port
module graphics_device_model (
  input wire logic i_clk_sys,
  input wire logic i_mode3,
  input wire logic i_port_bus_grant,
  output logic o_port_bus_request,
  output logic o_pipelined_request,
  output logic o_port_frame,
  output logic [31:0] o_port_addr_data,
  output logic [3:0] o_port_cmd_byte_en,
  output logic o_port_parity,
  output logic o_low_half_invert_flag
);
  logic par_prev;
  // Asserted level of a control line in the current mode
  function automatic logic lv(input logic a);
    return i_mode3 ? a : ~a;
  endfunction
  // Quiet bus: controls off, parity held high, other released lines keep changing
  task automatic idle();
    o_port_bus_request = lv(1'b0);
    o_pipelined_request = lv(1'b0);
    o_port_frame = lv(1'b0);
    o_port_addr_data = ~o_port_addr_data;
    o_port_cmd_byte_en = ~o_port_cmd_byte_en;
    o_port_parity = 1'b1;
    o_low_half_invert_flag = ~o_low_half_invert_flag;
  endtask
  // One single-rate period; parity trails its phase by one period
  task automatic phase(input logic frm, input logic [31:0] ad, input logic [3:0] cbe,
    input logic bad, input logic inv);
    o_port_frame = lv(frm);
    o_port_parity = par_prev;
    o_port_addr_data = inv ? {ad[31:16], ~ad[15:0]} : ad;
    o_low_half_invert_flag = inv;
    o_port_cmd_byte_en = i_mode3 ? cbe : ~cbe;
    par_prev = ^{o_port_addr_data, o_port_cmd_byte_en} ^ bad;
    repeat (8) @(negedge i_clk_sys);
  endtask
  // Optional request, then a bounded wait for the grant
  task automatic get_bus(input logic req, output bit ok);
    o_port_bus_request = lv(req);
    ok = 1'b0;
    for (int n = 0; n < 100 && !ok; n++) begin
      @(negedge i_clk_sys);
      ok = (i_port_bus_grant === lv(1'b1));
    end
  endtask
  // Frame-based write, frame dropped on the last data phase
  task automatic frame_write(input logic [31:0] a, input logic [31:0] d [3], input int bad,
    output bit ok);
    get_bus(1'b1, ok);
    if (ok) begin
      o_port_bus_request = lv(1'b0);
      phase(1'b1, a, 4'h7, 1'b0, 1'b0);
      for (int i = 0; i < 3; i++) phase(i < 2, d[i], 4'hf, i == bad, 1'b0);
      phase(1'b0, ~d[2], 4'h0, 1'b0, 1'b0);
    end
    idle();
  endtask
  // Pipelined request with frame left inactive
  task automatic pipe_req(input logic [31:0] a, output bit ok);
    get_bus(1'b1, ok);
    if (ok) begin
      o_pipelined_request = lv(1'b1);
      phase(1'b0, a, 4'h6, 1'b0, 1'b0);
    end
    idle();
  endtask
  // Queued write data, odd words sent inverted in the 3.0 mode
  task automatic q_write(input logic [31:0] d [3], output bit ok);
    get_bus(1'b0, ok);
    for (int i = 0; ok && i < 3; i++) phase(1'b0, d[i], 4'hf, 1'b0, i[0] & i_mode3);
    idle();
  endtask
  initial begin
    par_prev = 1'b0;
    o_port_addr_data = 32'h0;
    o_port_cmd_byte_en = 4'h0;
    o_low_half_invert_flag = 1'b0;
    o_port_bus_request = 1'b0;
    o_pipelined_request = 1'b0;
    o_port_frame = 1'b0;
    o_port_parity = 1'b1;
  end
endmodule // graphics_device_model

// file: tb/graphics_port_bus_signals_test.sv
`timescale 1ns/1ps
`include "graphics_port_cfg.svh"
module graphics_port_bus_signals_test;
  logic clk, rst, mode3, qv, qw, qready, take, avalid, apipe, rvalid, perr, str_bad;
  logic d_req, d_pipe, d_frame, d_par, d_dbi, grant, claim, claim_oe_n, ad_oe_n, cbe_oe_n;
  logic par_oe_n, dbi_oe_n, sf, ss, par_o, dbi_o, sf_last, ss_last, g_last;
  logic claim_seen, perr_seen, inv_seen, dbi_seen;
  logic [1:0] rate;
  logic [2:0] gst, st_seen;
  logic [3:0] qlen, tx_idx, d_cbe, cbe_o, cmd, rbe;
  logic [31:0] d_ad, ad_o, addr, rx;
  logic [31:0] tx_w [16];
  logic [36:0] aq [$];
  logic [31:0] rq [$];
  logic [31:0] dq [$];
  int err_count, n_checks;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  graphics_port_hub i_dut (.i_clk_sys(clk), .i_rst(rst), .i_mode3(mode3), .i_rate_sel(rate),
    .i_port_bus_request(d_req), .i_pipelined_request(d_pipe), .i_port_frame(d_frame),
    .o_port_bus_grant(grant), .o_grant_status_code(gst), .o_target_claim(claim),
    .o_target_claim_oe_n(claim_oe_n), .i_port_addr_data(ad_oe_n ? d_ad : ad_o),
    .o_port_addr_data(ad_o), .o_port_addr_data_oe_n(ad_oe_n),
    .i_port_cmd_byte_en(cbe_oe_n ? d_cbe : cbe_o), .o_port_cmd_byte_en(cbe_o),
    .o_port_cmd_byte_en_oe_n(cbe_oe_n), .i_port_parity(par_oe_n ? d_par : par_o),
    .o_port_parity(par_o), .o_port_parity_oe_n(par_oe_n),
    .i_low_half_invert_flag(dbi_oe_n ? d_dbi : dbi_o), .o_low_half_invert_flag(dbi_o),
    .o_low_half_invert_flag_oe_n(dbi_oe_n), .o_upper_first_strobe(sf),
    .o_upper_second_strobe(ss), .i_queue_valid(qv), .i_queue_write(qw), .i_queue_len(qlen),
    .o_queue_ready(qready), .i_tx_data(tx_w[tx_idx]), .o_tx_take(take),
    .o_addr_valid(avalid), .o_addr_pipelined(apipe), .o_addr(addr), .o_cmd(cmd),
    .o_rx_valid(rvalid), .o_rx_data(rx), .o_rx_be(rbe), .o_parity_error(perr));
  graphics_device_model i_dev (.i_clk_sys(clk), .i_mode3(mode3), .i_port_bus_grant(grant),
    .o_port_bus_request(d_req), .o_pipelined_request(d_pipe), .o_port_frame(d_frame),
    .o_port_addr_data(d_ad), .o_port_cmd_byte_en(d_cbe), .o_port_parity(d_par),
    .o_low_half_invert_flag(d_dbi));
  // Next queued read word on each take
  always @(posedge clk) if (take === 1'b1) tx_idx <= tx_idx + 4'h1;
  function automatic logic lv(input logic a);
    return mode3 ? a : ~a;
  endfunction
  // Record what the hub hands out, sampled mid-cycle
  always @(negedge clk) begin
    if (avalid === 1'b1) aq.push_back({apipe, cmd, addr});
    if (rvalid === 1'b1) rq.push_back(rx);
    // One item per rising edge of either strobe
    if ((sf === 1'b1 && sf_last !== 1'b1) || (ss === 1'b1 && ss_last !== 1'b1)) begin
      dq.push_back((dbi_o === 1'b1 && dbi_oe_n === 1'b0) ? ad_o ^ 32'h0000_ffff : ad_o);
      inv_seen |= (dbi_o === 1'b1 && dbi_oe_n === 1'b0);
      str_bad |= (ss !== ~sf);
    end
    claim_seen |= (claim_oe_n === 1'b0 && claim === lv(1'b1));
    perr_seen |= (perr === 1'b1);
    dbi_seen |= (dbi_oe_n === 1'b0);
    if (grant === lv(1'b1) && g_last !== lv(1'b1)) st_seen = gst;
    g_last = grant;
    sf_last = sf;
    ss_last = ss;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic c, input string msg);
    n_checks++;
    if (c !== 1'b1) begin
      err_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic timeout();
    err_count++;
    $display("mismatch at %0t: wait ran out", $time);
    stop_test();
  endtask
  task automatic clear();
    aq = {};
    rq = {};
    dq = {};
    {claim_seen, perr_seen, inv_seen, dbi_seen, str_bad} = 5'h0;
    st_seen = 3'h5;
  endtask
  // Reset in the given mode, then a quiet spell with no grant
  task automatic t_reset(input logic m);
    mode3 = m;
    rst = 1'b1;
    // Let the new mode reach the model before it sets idle levels
    @(negedge clk);
    i_dev.idle();
    repeat (11) @(negedge clk);
    check(gst === 3'h7 && ad_oe_n && cbe_oe_n && claim_oe_n && par_oe_n && dbi_oe_n, "reset");
    rst = 1'b0;
    clear();
    repeat (40) @(negedge clk);
    check(st_seen === 3'h5 && !claim_seen, "idle grant");
  endtask
  // Queue request held until the hub takes it
  task automatic q_req(input logic w, input logic [3:0] n);
    bit ok;
    ok = 1'b0;
    qw = w;
    qlen = n;
    qv = 1'b1;
    for (int i = 0; i < 100 && !ok; i++) begin
      #1 ok = (qready === 1'b1);
      @(negedge clk);
    end
    qv = 1'b0;
    if (!ok) timeout();
  endtask
  // Frame-based write, hit or miss, optional parity fault
  task automatic t_fw(input logic [31:0] a, input int bad, input logic hit);
    logic [31:0] d [3];
    bit ok;
    d = '{32'h1357_9bdf, 32'hffff_0000, 32'h0f0f_a5a5};
    clear();
    i_dev.frame_write(a, d, bad, ok);
    if (!ok) timeout();
    repeat (24) @(negedge clk);
    check(st_seen === 3'h7, "master grant status");
    check(aq.size() == 1 && aq[0] === {1'b0, 4'h7, a}, "frame address");
    check(!hit || rq.size() == 3 && rq[0] === d[0] && rq[2] === d[2], "frame data");
    check(claim_seen === hit, "claim");
    check(perr_seen === (hit && bad >= 0), "parity");
  endtask
  task automatic t_pipe(input logic [31:0] a);
    bit ok;
    clear();
    i_dev.pipe_req(a, ok);
    if (!ok) timeout();
    repeat (24) @(negedge clk);
    check(aq.size() == 1 && aq[0] === {1'b1, 4'h6, a}, "pipelined address");
    check(!claim_seen && rq.size() == 0, "pipelined claim");
  endtask
  // Queued read at a rate; words whose low half toggles widely
  task automatic t_qread(input logic [1:0] r, input logic [3:0] n);
    int k;
    clear();
    rate = r;
    tx_idx = 4'h0;
    for (k = 0; k < 16; k++) tx_w[k] = {16'ha500 + k[15:0], k[0] ? 16'hffff : 16'h00f0};
    q_req(1'b0, n);
    for (k = 0; k < 600 && dq.size() < n; k++) @(negedge clk);
    if (dq.size() < n) timeout();
    repeat (30) @(negedge clk);
    check(st_seen === 3'h0, "read status");
    check(dq.size() == n, "item count");
    for (k = 0; k < n; k++) check(dq[k] === tx_w[k], "read data");
    check(inv_seen === mode3 && dbi_seen === mode3, "inversion use");
    check(!claim_seen && !str_bad, "claim or strobes");
  endtask
  task automatic t_qwrite();
    logic [31:0] d [3];
    bit ok;
    d = '{32'h2468_0000, 32'h1111_ffff, 32'h8000_00ff};
    clear();
    rate = 2'h0;
    fork
      q_req(1'b1, 4'h3);
      i_dev.q_write(d, ok);
    join
    if (!ok) timeout();
    repeat (24) @(negedge clk);
    check(st_seen === 3'h2, "write status");
    check(rq.size() == 3 && rq[0] === d[0] && rq[1] === d[1] && rq[2] === d[2], "wr data");
  endtask
  initial begin
    err_count = 0;
    n_checks = 0;
    {rst, mode3, qv, qw, sf_last, ss_last, g_last} = 7'h40;
    rate = 2'h0;
    qlen = 4'h0;
    tx_idx = 4'h0;
    foreach (tx_w[k]) tx_w[k] = 32'h0;
    t_reset(1'b0);
    t_fw(`CLAIM_BASE + 32'h40, -1, 1'b1);
    t_qread(2'h2, 4'h4);
    t_reset(1'b1);
    t_fw(`CLAIM_BASE + 32'h40, 1, 1'b1);
    t_fw(32'h0020_0000, -1, 1'b0);
    t_pipe(`CLAIM_BASE + 32'h80);
    t_qread(2'h0, 4'h5);
    t_qread(2'h1, 4'h5);
    t_qread(2'h2, 4'hf);
    t_qwrite();
    stop_test();
  end
endmodule // graphics_port_bus_signals_test
